// *** registered_sop_logic_array_bench.sv ***
/*
  self-checking bench for the sum-of-products array.
  assumes sop_cfg.svh in the include path and the board model beside it.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
  $display("wrong value at %0t got %h exp %h", $time, a, b); end end
module registered_sop_logic_array_bench;
  import sop_pkg::*;
  logic clock, resetn, outEnableN, securityFuse, preloadMode, combVariant;
  logic [1:0] combExtraIn;
  logic [7:0] dedIn, regMode, pinIn, pinOut, pinOe, extDrive, extEn;
  logic [5:0] readRow;
  logic [2047:0] fuseMap;
  logic [255:0] enableFuse;
  logic [31:0] readData;
  logic ready;
  int n_errors = 0;
  int cmp_count = 0;
  sop_array i_sop_array (.clock(clock), .resetn(resetn), .dedIn(dedIn), .outEnableN(outEnableN),
    .regMode(regMode), .combVariant(combVariant), .combExtraIn(combExtraIn), .fuseMap(fuseMap),
    .enableFuse(enableFuse), .securityFuse(securityFuse), .preloadMode(preloadMode),
    .readRow(readRow), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .readData(readData),
    .ready(ready));
  sop_board i_sop_board (.pinOut(pinOut), .pinOe(pinOe), .extDrive(extDrive), .extEn(extEn),
    .pinIn(pinIn));
  ////////////////////////////////////////////////////////////////////////////////
  // free-running 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // registers come up low, pins high, and stay so through the settle span
  task automatic t_powerup;
    `CHK(pinOut, 8'hFF)
    `CHK(pinOe, 8'h00)
    @(posedge clock) resetn <= 1'b1;
    tick(190);
    `CHK({ready, pinOut}, 9'h0FF)
    tick(12);
    `CHK(ready, 1'b1)
    $display("test powerup done");
  endtask
  // empty term high, both-polarity term low, true and complement taps, rising-edge capture
  task automatic t_logic(input logic d0);
    @(posedge clock) dedIn <= {7'h00, d0};
    tick(2);
    `CHK(pinOut, {4'h1, d0, ~d0, 2'h2})
    `CHK(pinOe, 8'hFF)
    @(posedge clock) outEnableN <= 1'b1;
    tick(2);
    `CHK(pinOe, 8'h00)
    @(posedge clock) outEnableN <= 1'b0;
    $display("test logic done");
  endtask
  // an arbitrary state forced through the pins, then normal clocking resumes
  task automatic t_preload;
    @(posedge clock) begin
      preloadMode <= 1'b1;
      extDrive <= 8'hA5;
      extEn <= 8'hFF;
    end
    tick(3);
    `CHK({pinOe, pinOut}, 16'h00A5)
    @(posedge clock) begin
      preloadMode <= 1'b0;
      extEn <= 8'h00;
    end
    tick(1);
    `CHK({pinOe, pinOut}, 16'hFFA5)
    tick(1);
    // output 4 holds its own state, so the forced one survives the first capture
    `CHK(pinOut, 8'h06)
    $display("test preload done");
  endtask
  // readback shows the row until the security fuse hides it
  task automatic t_readback;
    @(posedge clock) readRow <= 6'h08;
    tick(2);
    `CHK(readData, 32'h00000003)
    @(posedge clock) securityFuse <= 1'b1;
    tick(2);
    `CHK(readData, 32'hFFFFFFFF)
    $display("test readback done");
  endtask
  // combinatorial output enable follows its own product term
  task automatic t_comb;
    @(posedge clock) regMode <= 8'hEF;
    tick(2);
    `CHK(pinOe[4], 1'b1)
    @(posedge clock) enableFuse[129:128] <= 2'h3;
    tick(2);
    `CHK(pinOe[4], 1'b0)
    `CHK(pinOut[4], 1'b0)
    // the released pin now feeds the array from the board side
    @(posedge clock) extEn <= 8'h10;
    tick(2);
    `CHK(pinOut[4], 1'b1)
    $display("test comb done");
  endtask
  // fully combinatorial variant: outputs 0 and 7 always drive, extra input 0 reaches the array
  task automatic t_variant;
    @(posedge clock) begin
      combVariant <= 1'b1;
      enableFuse[1:0] <= 2'h3;
      enableFuse[176] <= 1'b1;
    end
    tick(2);
    `CHK(pinOe, 8'hCF)
    @(posedge clock) combExtraIn <= 2'h1;
    tick(2);
    `CHK(pinOe, 8'hEF)
    $display("test variant done");
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence; fuse rows built so outputs 1..3 test low, true and complement terms
  initial begin
    {resetn, outEnableN, securityFuse, preloadMode, combVariant, combExtraIn, dedIn, extDrive, extEn} = '0;
    {regMode, readRow, fuseMap, enableFuse} = {8'hFF, 6'h00, 2048'h0, 256'h0};
    for (int t = 0; t < 8; t++) begin
      fuseMap[(8 + t) * 32 +: 2] = 2'b11;
      fuseMap[(16 + t) * 32 +: 2] = (t == 0) ? 2'h1 : 2'h3;
      fuseMap[(24 + t) * 32 +: 2] = (t == 0) ? 2'h2 : 2'h3;
      fuseMap[(32 + t) * 32 + 24] = 1'b1;
    end
    tick(16);
    t_powerup();
    t_logic(1'b1);
    t_logic(1'b0);
    t_preload();
    t_readback();
    t_comb();
    t_variant();
    results();
  end
  // watchdog: the whole run needs well under 400 cycles
  initial begin
    #5000;
    n_errors++;
    results();
  end
endmodule // registered_sop_logic_array_bench

// *** sop_array.sv ***
/*
  registered sum-of-products array: 8 dedicated inputs, 8 outputs each either a D register
  (pin-enabled, inverted) or a combinatorial I/O (term-enabled), fuse map from ports.
  assumes the fuse map and variant straps are static while running and all inputs are
  synchronous to clock.
*/
`timescale 1ns/1ps
module sop_array
  import sop_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [`SOP_NUM_DED-1:0] dedIn,
  input wire logic outEnableN,
  input wire logic [`SOP_NUM_OUT-1:0] regMode,
  input wire logic combVariant,
  input wire logic [1:0] combExtraIn,
  input wire logic [`SOP_NUM_OUT*`SOP_TERMS*`SOP_COLS-1:0] fuseMap,
  input wire logic [`SOP_NUM_OUT*`SOP_COLS-1:0] enableFuse,
  input wire logic securityFuse,
  input wire logic preloadMode,
  input wire logic [5:0] readRow,
  input wire logic [`SOP_NUM_OUT-1:0] pinIn,
  output logic [`SOP_NUM_OUT-1:0] pinOut,
  output logic [`SOP_NUM_OUT-1:0] pinOe,
  output logic [`SOP_COLS-1:0] readData,
  output logic ready
);

  ////////////////////////////////////////////////////////////////////////////
  // state and next values
  sop_state_t state;
  sop_state_t next_state;
  logic [15:0] pwrCount;
  logic [15:0] next_pwrCount;
  logic [`SOP_NUM_OUT-1:0] regQ;
  logic [`SOP_NUM_OUT-1:0] next_regQ;
  logic [`SOP_NUM_OUT-1:0] next_pinOut;
  logic [`SOP_NUM_OUT-1:0] next_pinOe;
  logic [`SOP_COLS-1:0] next_readData;
  logic next_ready;
  sop_sig_t sigTrue;
  logic [`SOP_COLS-1:0] cols;
  logic [`SOP_NUM_OUT-1:0] sumTerm;
  logic [`SOP_NUM_OUT-1:0] enTerm;
  logic [`SOP_NUM_OUT-1:0] combOut;

  ////////////////////////////////////////////////////////////////////////////
  // array column sources: inputs plus feedback from registers or I/O pins
  always_comb begin
    sigTrue[`SOP_NUM_DED-1:0] = dedIn;
    for (int i = 0; i < `SOP_NUM_OUT; i++) begin
      // registers feed back whatever their buffer enable, pins otherwise
      sigTrue[`SOP_NUM_DED+i] = (regMode[i] && !combVariant) ? regQ[i] : pinIn[i];
    end
    // combinatorial variant: the two output-only slots become the extra inputs
    if (combVariant) begin
      sigTrue[`SOP_NUM_DED] = combExtraIn[0];
      sigTrue[`SOP_NUM_DED+`SOP_NUM_OUT-1] = combExtraIn[1];
    end
    for (int j = 0; j < `SOP_NUM_SIG; j++) begin
      cols[2*j] = sigTrue[j];
      cols[2*j+1] = ~sigTrue[j];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AND plane: fuse bit 1 means connected; unconnected columns read as 1
  always_comb begin
    for (int o = 0; o < `SOP_NUM_OUT; o++) begin
      sumTerm[o] = 1'b0;
      for (int t = 0; t < `SOP_TERMS; t++) begin
        // combinatorial outputs use seven sum terms; the eighth row is unused
        // the fully combinatorial variant has no registers, so it always takes seven terms
        if ((regMode[o] && !combVariant) || t < `SOP_TERMS - 1) begin
          sumTerm[o] = sumTerm[o] | (&(cols | ~fuseMap[(o*`SOP_TERMS+t)*`SOP_COLS +: `SOP_COLS]));
        end
      end
      enTerm[o] = &(cols | ~enableFuse[o*`SOP_COLS +: `SOP_COLS]);
      combOut[o] = ~sumTerm[o];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing, registers and pin drivers
  always_comb begin
    next_state = state;
    next_pwrCount = pwrCount;
    next_regQ = regQ;
    next_ready = 1'b0;
    case (state)
      SOP_PWRUP: begin
        // clock edges are not used for logic until the power-up delay ends
        if (pwrCount >= 16'(`SOP_PWRUP_CYCLES - 1)) begin
          next_state = SOP_RUN;
        end else begin
          next_pwrCount = pwrCount + 16'h0001;
        end
      end
      SOP_RUN: begin
        next_ready = 1'b1;
        if (preloadMode) begin
          next_state = SOP_PRELOAD;
        end else begin
          for (int o = 0; o < `SOP_NUM_OUT; o++) begin
            if (regMode[o] && !combVariant) begin
              next_regQ[o] = sumTerm[o];
            end
          end
        end
      end
      SOP_PRELOAD: begin
        next_ready = 1'b1;
        // pins carry the wanted output level; register holds its complement.
        // loading stops with the mode pin, so the board may release the pins
        // on that same edge without overwriting the forced state
        if (preloadMode) begin
          for (int o = 0; o < `SOP_NUM_OUT; o++) begin
            if (regMode[o]) begin
              next_regQ[o] = ~pinIn[o];
            end
          end
        end else begin
          next_state = SOP_RUN;
        end
      end
      default: begin
        next_state = SOP_PWRUP;
      end
    endcase
    for (int o = 0; o < `SOP_NUM_OUT; o++) begin
      if (regMode[o] && !combVariant) begin
        next_pinOut[o] = ~next_regQ[o];
        next_pinOe[o] = ~outEnableN && (next_state != SOP_PRELOAD);
      end else begin
        next_pinOut[o] = combOut[o];
        // outputs 0 and 7 of the combinatorial variant are output-only
        next_pinOe[o] = (combVariant && (o == 0 || o == `SOP_NUM_OUT - 1)) ? 1'b1 : enTerm[o];
      end
    end
    // readback: secured parts show every fuse as programmed (connected);
    // the 6-bit row address spans the AND rows only, so enable rows are not read back
    if (securityFuse) begin
      next_readData = '1;
    end else begin
      next_readData = fuseMap[readRow*`SOP_COLS +: `SOP_COLS];
    end
  end

  // asynchronous reset stands in for power-up; registers clear LOW, pins high
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= SOP_PWRUP;
      pwrCount <= 16'h0000;
      regQ <= {`SOP_NUM_OUT{`SOP_REG_RESET}};
      pinOut <= 8'hFF;
      pinOe <= 8'h00;
      readData <= 32'h00000000;
      ready <= 1'b0;
    end else begin
      state <= next_state;
      pwrCount <= next_pwrCount;
      regQ <= next_regQ;
      pinOut <= next_pinOut;
      pinOe <= next_pinOe;
      readData <= next_readData;
      ready <= next_ready;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  pwrup_clear_a: assert property (@(posedge clock) disable iff (!resetn)
    (state == SOP_PWRUP) |-> (regQ == 8'h00))
    else $error("register not clear during power-up");
  pwrup_bound_a: assert property (@(posedge clock) disable iff (!resetn)
    (state == SOP_PWRUP) |-> (pwrCount < 16'(`SOP_PWRUP_CYCLES)))
    else $error("power-up delay overran");
  reg_capture_a: assert property (@(posedge clock) disable iff (!resetn)
    (state == SOP_RUN && !preloadMode && regMode[0] && !combVariant) |=> (regQ[0] == $past(sumTerm[0])))
    else $error("register missed sum term");
  preload_load_a: assert property (@(posedge clock) disable iff (!resetn)
    (state == SOP_PRELOAD && preloadMode && regMode[1]) |=> (regQ[1] == ~$past(pinIn[1])))
    else $error("preload value not taken");
  out_invert_a: assert property (@(posedge clock) disable iff (!resetn)
    (regMode[2] && !combVariant && $stable(regMode)) |=> (pinOut[2] == ~regQ[2]))
    else $error("registered pin not inverted");
  shared_oe_a: assert property (@(posedge clock) disable iff (!resetn)
    (regMode[3] && !combVariant && outEnableN) |=> !pinOe[3])
    else $error("registered pin driven while disabled");
  term_oe_a: assert property (@(posedge clock) disable iff (!resetn)
    (!regMode[4] && !combVariant) |=> (pinOe[4] == $past(enTerm[4])))
    else $error("enable term not followed");
  secure_read_a: assert property (@(posedge clock) disable iff (!resetn)
    securityFuse |=> (readData == 32'hFFFFFFFF))
    else $error("secured readback leaked pattern");
  // preload floats the registered pins; output-only pins never float
  preload_float_a: assert property (@(posedge clock) disable iff (!resetn)
    (state == SOP_PRELOAD && regMode[3] && !combVariant) |-> !pinOe[3])
    else $error("registered pin driven during preload");
  output_only_a: assert property (@(posedge clock) disable iff (!resetn)
    combVariant |=> (pinOe[0] && pinOe[7]))
    else $error("output-only pin not driven");
endmodule // sop_array

// *** sop_board.sv ***
/*
  board model: resolves the eight output pins from the array drive and a bench drive.
  assumes one clock domain; an undriven pin sits on a board pull-up.
*/
`timescale 1ns/1ps
module sop_board (
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOe,
  input wire logic [7:0] extDrive,
  input wire logic [7:0] extEn,
  output logic [7:0] pinIn
);
  // the array wins where it drives; the pull-up keeps a released pin off a stale value
  always_comb begin
    pinIn = (pinOe & pinOut) | (~pinOe & extEn & extDrive) | (~pinOe & ~extEn);
  end
endmodule // sop_board

// *** sop_cfg.svh ***
/*
  timing counts, fuse-map geometry and reset values for the sum-of-products array.
  assumes a 200 MHz core clock; included by bare name.
*/
`ifndef SOP_CFG_SVH
`define SOP_CFG_SVH
`define SOP_CLK_PERIOD_PS 5000
`define SOP_PWRUP_NS 1000
`define SOP_PWRUP_CYCLES ((`SOP_PWRUP_NS * 1000) / `SOP_CLK_PERIOD_PS)
`define SOP_NUM_DED 8
`define SOP_NUM_OUT 8
`define SOP_NUM_SIG 16
`define SOP_COLS 32
`define SOP_TERMS 8
`define SOP_REG_RESET 1'b0
`endif

// *** sop_pkg.sv ***
/*
  types shared by the sum-of-products array.
  assumes sop_cfg.svh sits in the include path.
*/
`include "sop_cfg.svh"
package sop_pkg;
  typedef logic [`SOP_COLS-1:0] sop_row_t;
  typedef logic [`SOP_NUM_SIG-1:0] sop_sig_t;
  typedef enum logic [1:0] {
    SOP_PWRUP = 2'b00,
    SOP_RUN = 2'b01,
    SOP_PRELOAD = 2'b11
  } sop_state_t;
endpackage
